// >>> common/sastc_consts.svh
`ifndef SASTC_CONSTS_SVH
`define SASTC_CONSTS_SVH

// ==================================================
// serial frame
`define SASTC_FRAME_BITS     5'h10
`define SASTC_LAST_BIT       5'h0f
`define SASTC_TRACK_EDGE     5'h0e
`define SASTC_ALL_ONES       16'hffff
`define SASTC_CTRL_RESET     16'h0000

// ==================================================
// channel tags
`define SASTC_TEMP_TAG       4'h8
`define SASTC_ANALOG_TAG_MSB 1'h0

// ==================================================
// temperature timing
`define SASTC_TEMP_CONV_NS   100000
`define SASTC_CLK_PERIOD_NS  10

// ==================================================
// averaging weights
`define SASTC_AVG_WEIGHT     7
`define SASTC_AVG_SHIFT      3
`define SASTC_AVG_GUARD      3

`endif

// >>> common/sastc_pkg.sv
package sastc_pkg;

   // ==================================================
   // control word as shifted in, write flag first
   typedef struct packed {
      logic       write;
      logic [5:0] spare_hi;
      logic [2:0] chan;
      logic       avg_en;
      logic       spare_mid;
      logic       pd;
      logic       external_reference_select;
      logic       temp_sense_select;
      logic       spare_lo;
   } sastc_ctrl_s;

   // ==================================================
   // output word: channel tag then result
   typedef struct packed {
      logic [3:0]  tag;
      logic [11:0] data;
   } sastc_word_s;

   // ==================================================
   // temperature frame tracking
   typedef enum logic [2:0] {
      SASTC_T_IDLE = 3'b001,
      SASTC_T_READ = 3'b010,
      SASTC_T_WAIT = 3'b100
   } sastc_tstate_e;

endpackage

// >>> verilog/sastc_sync.sv
`timescale 1ns/1ps
module sastc_sync
#(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_reg;

   // ==================================================
   // two-stage level synchroniser
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_reg <= RST_VAL;
         q_out    <= RST_VAL;
      end
      else
      begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end

endmodule

// >>> verilog/sastc_avg.sv
`timescale 1ns/1ps
`include "sastc_consts.svh"
module sastc_avg
#(
   parameter int W = 12
)
(
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         clear_in,
   input  wire logic         enable_in,
   input  wire logic         sample_in,
   input  wire logic [W-1:0] raw_in,
   output logic      [W-1:0] avg_out
);

   localparam int XW = W + `SASTC_AVG_GUARD;

   logic          primed_reg;
   logic [XW-1:0] prev_x;
   logic [XW-1:0] raw_x;
   logic [XW-1:0] sum_x;
   logic [XW-1:0] mix_x;

   if (W < 2)
   begin : g_chk
      $error("sastc_avg: width too small");
   end

   // ==================================================
   // seven eighths previous plus one eighth new, signed
   assign prev_x = {{`SASTC_AVG_GUARD{avg_out[W-1]}}, avg_out};
   assign raw_x  = {{`SASTC_AVG_GUARD{raw_in[W-1]}}, raw_in};
   assign sum_x  = XW'(prev_x * XW'(`SASTC_AVG_WEIGHT)) + raw_x;
   assign mix_x  = XW'($signed(sum_x) >>> `SASTC_AVG_SHIFT);

   // ==================================================
   // result register; raw value until primed
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         avg_out    <= '0;
         primed_reg <= 1'b0;
      end
      else if (sample_in)
      begin
         if (enable_in && primed_reg && !clear_in)
            avg_out <= mix_x[W-1:0];
         else
            avg_out <= raw_in;
         primed_reg <= enable_in;
      end
      else if (clear_in || !enable_in)
      begin
         primed_reg <= 1'b0;
      end
   end

endmodule

// >>> verilog/sastc_top.sv
`timescale 1ns/1ps
`include "sastc_consts.svh"
module sastc_top
   import sastc_pkg::*;
#(
   parameter int TEMP_CONV_CYC = `SASTC_TEMP_CONV_NS / `SASTC_CLK_PERIOD_NS,
   parameter int RES_W         = 12
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             sclk_in,
   input  wire logic             cs_n_in,
   input  wire logic             din_in,
   input  wire logic [RES_W-1:0] adc_code_in,
   input  wire logic [RES_W-1:0] temp_code_in,
   output logic                  dout_out,
   output logic                  dout_oe_out,
   output logic                  sample_hold_out,
   output logic [2:0]            channel_select_out,
   output logic                  temp_sense_select_out,
   output logic                  temp_average_enable_out,
   output logic                  external_reference_select_out,
   output logic                  powerdown_control_out,
   output logic                  temp_conversion_busy_out,
   output logic                  temp_done_out,
   output logic [RES_W-1:0]      temp_result_out
);

   localparam int CW = $clog2(TEMP_CONV_CYC + 1);

   // ==================================================
   // elaboration checks
   if (TEMP_CONV_CYC < 1)
   begin : g_chk_cyc
      $error("sastc_top: TEMP_CONV_CYC must be at least 1");
   end
   if (RES_W != 12)
   begin : g_chk_res
      $error("sastc_top: RES_W must be 12");
   end

   // ==================================================
   // serial clock domain signals
   logic          frame_rst;
   logic [4:0]    bit_cnt_reg;
   logic [14:0]   rx_sh_reg;
   sastc_ctrl_s   ctrl_reg;
   sastc_word_s   out_word_reg;
   sastc_word_s   tx_word;
   sastc_tstate_e tst_reg;
   sastc_tstate_e tst_next;
   sastc_ctrl_s   rx_word;
   logic          avg_tgl_reg;
   logic          abort_tgl_reg;
   logic          busy_cs_reg;
   logic          busy_frame_reg;
   logic          frame_end;
   logic          ignored;
   logic          temp_free;
   logic          temp_start_frame;
   logic          accept_wr;
   logic          pd_abort;

   // ==================================================
   // system clock domain signals
   logic [4:0]    cfg_sync;
   logic          cs_s;
   logic          temp_sense_select_s;
   logic          avg_s;
   logic          avg_tgl_s;
   logic          abort_tgl_s;
   logic          cs_prev_reg;
   logic          avg_tgl_d_reg;
   logic          abort_tgl_d_reg;
   logic          busy_reg;
   logic [CW-1:0] conv_cnt_reg;
   logic          cs_fall;
   logic          temp_start;
   logic          abort_ev;
   logic          avg_clear;
   logic          conv_done;

   assign frame_rst = cs_n_in | rst_in;

   // ==================================================
   // frame bit counter, cleared while select is high
   always_ff @(negedge sclk_in or posedge frame_rst)
   begin
      if (frame_rst)
         bit_cnt_reg <= '0;
      else if (bit_cnt_reg != `SASTC_FRAME_BITS)
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
   end

   assign frame_end = (bit_cnt_reg == `SASTC_LAST_BIT);

   // ==================================================
   // control word shift in
   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
         rx_sh_reg <= '0;
      else if (bit_cnt_reg < `SASTC_FRAME_BITS)
         rx_sh_reg <= {rx_sh_reg[13:0], din_in};
   end

   assign rx_word = {rx_sh_reg, din_in};

   // ==================================================
   // busy taken at select fall, retimed at first fall; serial clock may stop between frames
   always_ff @(negedge cs_n_in or posedge rst_in)
   begin
      if (rst_in)
         busy_cs_reg <= 1'b0;
      else
         busy_cs_reg <= busy_reg;
   end

   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
         busy_frame_reg <= 1'b0;
      else if (bit_cnt_reg == 5'h00)
         busy_frame_reg <= busy_cs_reg;
   end

   // ==================================================
   // frame classification
   assign ignored          = (tst_reg == SASTC_T_WAIT) && busy_frame_reg;
   assign temp_free        = (tst_reg == SASTC_T_IDLE) ||
                             ((tst_reg == SASTC_T_WAIT) && !busy_frame_reg);
   assign temp_start_frame = temp_free && ctrl_reg.temp_sense_select;
   assign accept_wr        = rx_word.write && !ignored;
   assign pd_abort         = temp_start_frame && accept_wr && rx_word.pd;

   // ==================================================
   // control register, updated only on a complete frame
   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
         ctrl_reg <= `SASTC_CTRL_RESET;
      else if (frame_end && accept_wr)
         ctrl_reg <= rx_word;
   end

   // ==================================================
   // averager restart and abort events as toggles
   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         avg_tgl_reg   <= 1'b0;
         abort_tgl_reg <= 1'b0;
      end
      else if (frame_end)
      begin
         if (accept_wr && (rx_word.avg_en != ctrl_reg.avg_en))
            avg_tgl_reg <= ~avg_tgl_reg;
         if (pd_abort)
            abort_tgl_reg <= ~abort_tgl_reg;
      end
   end

   // ==================================================
   // conversion result held for the following frame
   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
         out_word_reg <= '0;
      else if (frame_end && !ignored && !temp_start_frame)
      begin
         out_word_reg.tag  <= {`SASTC_ANALOG_TAG_MSB, ctrl_reg.chan};
         out_word_reg.data <= adc_code_in;
      end
   end

   // ==================================================
   // temperature frame tracking
   always_comb
   begin
      tst_next = tst_reg;
      case (tst_reg)
         SASTC_T_IDLE:
         begin
            if (ctrl_reg.temp_sense_select && !pd_abort)
               tst_next = SASTC_T_READ;
         end
         SASTC_T_READ:
         begin
            tst_next = SASTC_T_WAIT;
         end
         SASTC_T_WAIT:
         begin
            if (!busy_frame_reg)
            begin
               if (ctrl_reg.temp_sense_select && !pd_abort)
                  tst_next = SASTC_T_READ;
               else
                  tst_next = SASTC_T_IDLE;
            end
         end
         default:
         begin
            tst_next = SASTC_T_IDLE;
         end
      endcase
   end

   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
         tst_reg <= SASTC_T_IDLE;
      else if (frame_end)
         tst_reg <= tst_next;
   end

   // ==================================================
   // serial output word select
   // temp_result_out only changes while busy is high, so it is
   // static whenever busy_frame_reg reads low
   always_comb
   begin
      if (ignored)
         tx_word = `SASTC_ALL_ONES;
      else if (tst_reg == SASTC_T_WAIT)
      begin
         tx_word.tag  = `SASTC_TEMP_TAG;
         tx_word.data = temp_result_out;
      end
      else
         tx_word = out_word_reg;
   end

   // ==================================================
   // serial pins and sampler
   assign dout_out        = tx_word[~bit_cnt_reg[3:0]];
   assign dout_oe_out     = !frame_rst && (bit_cnt_reg < `SASTC_FRAME_BITS);
   assign sample_hold_out = !frame_rst && (bit_cnt_reg < `SASTC_TRACK_EDGE);

   // ==================================================
   // configuration outputs
   assign channel_select_out            = ctrl_reg.chan;
   assign temp_sense_select_out         = ctrl_reg.temp_sense_select;
   assign temp_average_enable_out       = ctrl_reg.avg_en;
   assign external_reference_select_out = ctrl_reg.external_reference_select;
   assign powerdown_control_out         = ctrl_reg.pd;

   // ==================================================
   // select, configuration and events into clk_in
   sastc_sync #(
      .W       (5),
      .RST_VAL (5'h10)
   ) u_cfg_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({cs_n_in, ctrl_reg.temp_sense_select, ctrl_reg.avg_en,
                avg_tgl_reg, abort_tgl_reg}),
      .q_out  (cfg_sync)
   );

   assign cs_s        = cfg_sync[4];
   assign temp_sense_select_s    = cfg_sync[3];
   assign avg_s       = cfg_sync[2];
   assign avg_tgl_s   = cfg_sync[1];
   assign abort_tgl_s = cfg_sync[0];

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cs_prev_reg     <= 1'b1;
         avg_tgl_d_reg   <= 1'b0;
         abort_tgl_d_reg <= 1'b0;
      end
      else
      begin
         cs_prev_reg     <= cs_s;
         avg_tgl_d_reg   <= avg_tgl_s;
         abort_tgl_d_reg <= abort_tgl_s;
      end
   end

   assign cs_fall    = cs_prev_reg && !cs_s;
   assign temp_start = cs_fall && temp_sense_select_s && !busy_reg;
   assign abort_ev   = abort_tgl_s ^ abort_tgl_d_reg;
   assign avg_clear  = avg_tgl_s ^ avg_tgl_d_reg;
   assign conv_done  = busy_reg && (conv_cnt_reg == '0) && !abort_ev;

   // ==================================================
   // temperature integration and conversion timer
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         busy_reg     <= 1'b0;
         conv_cnt_reg <= '0;
      end
      else if (abort_ev)
      begin
         busy_reg     <= 1'b0;
         conv_cnt_reg <= '0;
      end
      else if (temp_start)
      begin
         busy_reg     <= 1'b1;
         conv_cnt_reg <= CW'(TEMP_CONV_CYC - 1);
      end
      else if (busy_reg)
      begin
         if (conv_cnt_reg == '0)
            busy_reg <= 1'b0;
         else
            conv_cnt_reg <= conv_cnt_reg - CW'(1);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         temp_done_out <= 1'b0;
      else
         temp_done_out <= conv_done;
   end

   assign temp_conversion_busy_out = busy_reg;

   // ==================================================
   // moving average of temperature results
   sastc_avg #(
      .W (RES_W)
   ) u_avg (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .clear_in  (avg_clear),
      .enable_in (temp_sense_select_s && avg_s),
      .sample_in (conv_done),
      .raw_in    (temp_code_in),
      .avg_out   (temp_result_out)
   );

endmodule

// >>> tb/sastc_properties.sv
`timescale 1ns/1ps
module sastc_properties
#(
   parameter int TEMP_CONV_CYC = 10000,
   parameter int RES_W         = 12
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             cs_n_in,
   input  wire logic             dout_oe_out,
   input  wire logic             sample_hold_out,
   input  wire logic             temp_sense_select_out,
   input  wire logic             powerdown_control_out,
   input  wire logic             temp_conversion_busy_out,
   input  wire logic             temp_done_out,
   input  wire logic [RES_W-1:0] temp_result_out
);
   // ==================================================
   // busy length counter
   logic [15:0] busy_cnt_reg;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         busy_cnt_reg <= 16'h0000;
      else if (temp_conversion_busy_out)
         busy_cnt_reg <= busy_cnt_reg + 16'h0001;
      else
         busy_cnt_reg <= 16'h0000;
   end

   // ==================================================
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_frame_open;
      sample_hold_out && dout_oe_out;
   endsequence

   sequence s_busy_fall;
      temp_conversion_busy_out ##1 !temp_conversion_busy_out;
   endsequence

   AST_IDLE_FLOAT: assert property (cs_n_in |-> !dout_oe_out)
      else $error("serial output driven while deselected");
   AST_OPEN_FRAME: assert property ($fell(cs_n_in) |-> s_frame_open)
      else $error("frame start did not hold and drive");
   AST_TRACK_EARLY: assert property ($fell(sample_hold_out) && !cs_n_in |-> dout_oe_out)
      else $error("hold released after output floated");
   AST_BUSY_START: assert property ($rose(temp_conversion_busy_out) |->
      !cs_n_in && temp_sense_select_out)
      else $error("busy rose without a temperature frame");
   AST_BUSY_BOUND: assert property (temp_conversion_busy_out |->
      busy_cnt_reg < TEMP_CONV_CYC + 1)
      else $error("temperature conversion too long");
   AST_DONE_AFTER_BUSY: assert property (s_busy_fall |->
      temp_done_out || powerdown_control_out)
      else $error("no done pulse after busy fell");
   AST_DONE_CAUSE: assert property (temp_done_out |->
      $past(temp_conversion_busy_out) && !temp_conversion_busy_out)
      else $error("done pulse without busy end");
   AST_DONE_PULSE: assert property (temp_done_out |=> !temp_done_out)
      else $error("done longer than one cycle");
   AST_RESULT_AT_END: assert property ($changed(temp_result_out) |->
      $fell(temp_conversion_busy_out))
      else $error("temperature result changed outside completion");
endmodule

bind sastc_top sastc_properties #(.TEMP_CONV_CYC(TEMP_CONV_CYC), .RES_W(RES_W)) i_sastc_properties
(
   .clk_in                   (clk_in),
   .rst_in                   (rst_in),
   .cs_n_in                  (cs_n_in),
   .dout_oe_out              (dout_oe_out),
   .sample_hold_out          (sample_hold_out),
   .temp_sense_select_out    (temp_sense_select_out),
   .powerdown_control_out    (powerdown_control_out),
   .temp_conversion_busy_out (temp_conversion_busy_out),
   .temp_done_out            (temp_done_out),
   .temp_result_out          (temp_result_out)
);

// >>> tb/sastc_master.sv
`timescale 1ns/1ps
module sastc_master
(
   input  wire logic dout_in,
   input  wire logic dout_oe_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      din_out
);
   initial
   begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out  = 1'b0;
   end

   // ==================================================
   // one frame of n falls, 160 ns serial clock
   task automatic frame(input logic [15:0] wr, input int n, output logic [15:0] rd);
      rd = 'x;
      cs_n_out = 1'b0;
      #40;
      for (int i = 15; i >= 16 - n; i--)
      begin
         din_out = wr[i];
         #40;
         rd[i] = dout_oe_in ? dout_in : 1'bx;
         sclk_out = 1'b0;
         #80;
         sclk_out = 1'b1;
         #40;
      end
      cs_n_out = 1'b1;
      // released line shows no stale value
      din_out = ~din_out;
      #160;
   endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("mismatch %s expected %h seen %h", what, exp, got); \
      end \
   end
module testbench;
   localparam int CONV_CYC = 600;
   localparam int LIMIT    = 15000;
   logic        clk_in;
   logic        rst_in;
   logic        sclk;
   logic        cs_n;
   logic        din;
   logic [11:0] adc_code;
   logic [11:0] temp_code;
   logic        dout;
   logic        dout_oe;
   logic [2:0]  chan;
   logic        temp_sense_select;
   logic        avg_en;
   logic        external_reference_select;
   logic        pd;
   logic        busy;
   logic [11:0] result;
   logic [15:0] rd;
   int          fails       = 0;
   int          check_count = 0;
   int          cycles      = 0;

   sastc_top #(.TEMP_CONV_CYC(CONV_CYC), .RES_W(12)) i_sastc_top
   (
      .clk_in (clk_in), .rst_in (rst_in), .sclk_in (sclk), .cs_n_in (cs_n), .din_in (din),
      .adc_code_in (adc_code), .temp_code_in (temp_code), .dout_out (dout),
      .dout_oe_out (dout_oe), .sample_hold_out (), .channel_select_out (chan),
      .temp_sense_select_out (temp_sense_select), .temp_average_enable_out (avg_en),
      .external_reference_select_out (external_reference_select), .powerdown_control_out (pd),
      .temp_conversion_busy_out (busy), .temp_done_out (), .temp_result_out (result)
   );

   sastc_master i_sastc_master
   (
      .dout_in (dout), .dout_oe_in (dout_oe), .sclk_out (sclk), .cs_n_out (cs_n), .din_out (din)
   );

   // ==================================================
   // helpers
   function automatic logic [15:0] cw(input logic [2:0] c, input logic a, p, e, t);
      return {1'b1, 6'h00, c, a, 1'b0, p, e, t, 1'b0};
   endfunction

   task automatic xfer(input logic [15:0] wr, input int n, output logic [15:0] r);
      @(posedge clk_in);
      #2;
      i_sastc_master.frame(wr, n, r);
   endtask

   task automatic conv(input logic [15:0] wr, input logic [11:0] code, input logic [11:0] exp,
                       output logic [15:0] rd1);
      logic [15:0] r;
      int          k;
      @(posedge clk_in);
      temp_code <= code;
      xfer(wr, 16, rd1);
      xfer(16'h0000, 16, r);
      `CHK("read frame", 13'h05c3, {r[15], r[11:0]})
      xfer(16'h0000, 16, r);
      `CHK("frame during busy", 16'hffff, r)
      k = 0;
      while (busy !== 1'b0 && k < 2000)
      begin
         @(posedge clk_in);
         k++;
      end
      `CHK("busy end", 1'b0, busy)
      repeat (20) @(posedge clk_in);
      `CHK("temp result", exp, result)
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==================================================
   // clock and watchdog
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         fails++;
         summarize();
      end
   end

   // ==================================================
   // main sequence
   initial
   begin
      rst_in    = 1'b1;
      adc_code  = 12'h3a5;
      temp_code = 12'h000;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      `CHK("reset outputs", 9'h000, {chan, temp_sense_select, avg_en, external_reference_select, pd, busy, dout_oe})
      xfer(cw(3'h5, 1'b0, 1'b0, 1'b1, 1'b0), 16, rd);
      `CHK("control write", 4'hb, {chan, external_reference_select})
      xfer(16'h0080, 16, rd);
      `CHK("write flag clear", 3'h5, chan)
      @(posedge clk_in);
      adc_code <= 12'h5c3;
      xfer(16'h0000, 16, rd);
      `CHK("analog word", 16'h53a5, rd)
      xfer(cw(3'h0, 1'b0, 1'b0, 1'b0, 1'b0), 8, rd);
      `CHK("abort control", 4'hb, {chan, external_reference_select})
      `CHK("abort float", 1'b0, dout_oe)
      xfer(16'h0000, 16, rd);
      `CHK("after abort", 16'h55c3, rd)
      xfer(cw(3'h0, 1'b1, 1'b0, 1'b0, 1'b1), 16, rd);
      `CHK("temp config", 3'h6, {temp_sense_select, avg_en, external_reference_select})
      conv(16'h0000, 12'h064, 12'h064, rd);
      conv(16'h0000, 12'h0c8, 12'h070, rd);
      `CHK("temp word", 16'h8064, rd)
      conv(cw(3'h0, 1'b1, 1'b0, 1'b0, 1'b1), 12'h028, 12'h067, rd);
      conv(cw(3'h0, 1'b0, 1'b0, 1'b0, 1'b1), 12'hfff, 12'hfff, rd);
      `CHK("avg word", 16'h8067, rd)
      conv(16'h0000, 12'hf60, 12'hf60, rd);
      `CHK("minus quarter", 16'h8fff, rd)
      xfer(cw(3'h0, 1'b0, 1'b1, 1'b0, 1'b1), 16, rd);
      repeat (10) @(posedge clk_in);
      `CHK("pd abort busy", 2'h1, {busy, pd})
      `CHK("pd abort result", 12'hf60, result)
      summarize();
   end
endmodule
